// ==== sdm_top.v ====
// Self-test conversion sequencer with result register and AHB-Lite register slave
// What this block does
// - Self-test conversion runs only when enable bit set
// - Self-test starts right after last cell conversion
// - Aux conversions wait for power-up, cells, self-test
// - Result sits in upper three nibbles only
// - Self-test reference is thermistor supply node
// - Code is half reference-minus-node over supply
// - Healthy code lies 0x54B to 0x677
// - Fault codes 0x1DA-0x1DC, 0x292-0x293
// - Oscillating reference pin sets open alert flag
`include "sdm_defs.vh"
`default_nettype none
module sdm_top #(
	parameter CELLS = 12,
	parameter CONV_CYC = 8,
	parameter PWRUP_CYC = `SDM_PWRUP_CYC
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	input wire [11:0] i_adc_code,
	input wire i_adc_done,
	input wire i_ref_level,
	output reg o_adc_start,
	output reg [1:0] o_adc_sel,
	output reg o_ref_sel_thermistor,
	output reg o_irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_PWRUP = 3'h1;
	localparam ST_CELL = 3'h2;
	localparam ST_SELF = 3'h3;
	localparam ST_AUX1 = 3'h4;
	localparam ST_AUX2 = 3'h5;

	localparam SEL_CELL = 2'h0;
	localparam SEL_SELF = 2'h1;
	localparam SEL_AUX1 = 2'h2;
	localparam SEL_AUX2 = 2'h3;

	reg [15:0] cfg_reg;
	reg [15:0] cell_en_reg;
	reg [15:0] result_reg;
	reg fault_reg;
	reg [2:0] stat_reg;
	reg [2:0] mask_reg;

	reg [2:0] state_reg;
	reg [15:0] cnt_reg;
	reg [3:0] cell_reg;
	reg busy_reg;
	reg wait_reg;
	reg ph_valid_reg;
	reg ph_write_reg;
	reg [7:0] ph_addr_reg;

	reg scan_go;
	wire ref_osc;

	// A 64-cycle window keeps slow drift from tripping the alert
	sdm_osc_det #(
		.EDGES(`SDM_OSC_EDGES),
		.WIN(64)
	) u_osc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_level(i_ref_level),
		.o_detect(ref_osc)
	);

	// Next enabled cell at or after index, CELLS if none
	function [3:0] next_cell;
		input [15:0] en;
		input [3:0] from;
		integer k;
		reg found;
		begin
			next_cell = CELLS[3:0];
			found = 1'b0;
			for (k = 0; k < CELLS; k = k + 1) begin
				if (!found && k >= from && en[k]) begin
					next_cell = k[3:0];
					found = 1'b1;
				end
			end
		end
	endfunction

	// Read data for one register offset, zero when unmapped
	function [31:0] read_word;
		input [7:0] a;
		begin
			case (a)
			`SDM_OFF_CFG: read_word = {16'h0000, cfg_reg};
			`SDM_OFF_FAULT: read_word = {31'h00000000, fault_reg};
			`SDM_OFF_RESULT: read_word = {16'h0000, result_reg};
			`SDM_OFF_IRQ: read_word = {29'h00000000, stat_reg};
			`SDM_OFF_MASK: read_word = {29'h00000000, mask_reg};
			`SDM_OFF_STATE: read_word = {16'h0000, cell_en_reg};
			`SDM_OFF_CTRL: read_word = {28'h0000000, state_reg, busy_reg};
			default: read_word = 32'h00000000;
			endcase
		end
	endfunction

	wire [3:0] first_cell = next_cell(cell_en_reg, 4'h0);
	wire [3:0] after_cell = next_cell(cell_en_reg, cell_reg + 4'h1);

	wire selftest_enable_bit = cfg_reg[`SDM_CFG_SELFTEST_BIT];
	wire aux1_en = cfg_reg[`SDM_CFG_AUX1_BIT];
	wire aux2_en = cfg_reg[`SDM_CFG_AUX2_BIT];
	wire conv_fin = wait_reg && i_adc_done;

	// Bus address phase capture; writes complete with zero wait states
	wire ap = i_hsel && i_hready && i_htrans[1];
	always @(posedge i_clk) begin
		if (i_rst) begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg <= 8'h00;
		end else begin
			ph_valid_reg <= ap;
			ph_write_reg <= i_hwrite;
			ph_addr_reg <= i_haddr[7:0];
		end
	end

	wire wr = ph_valid_reg && ph_write_reg;
	wire rd_ap = ap && !i_hwrite;
	// Writes act in the data phase, when hwdata stands
	wire wr_cfg = wr && ph_addr_reg == `SDM_OFF_CFG;
	wire wr_cells = wr && ph_addr_reg == `SDM_OFF_STATE;
	wire wr_mask = wr && ph_addr_reg == `SDM_OFF_MASK;
	wire wr_fault = wr && ph_addr_reg == `SDM_OFF_FAULT;
	wire rd_stat = rd_ap && i_haddr[7:0] == `SDM_OFF_IRQ;

	// A start while busy is dropped, not queued
	always @* begin
		scan_go = 1'b0;
		if (wr && ph_addr_reg == `SDM_OFF_CTRL && !busy_reg) begin
			scan_go = i_hwdata[`SDM_CTRL_SCAN_BIT];
		end
	end

	// Sequencer: power-up, cells, self-test, then aux channels
	always @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			cell_reg <= 4'h0;
			busy_reg <= 1'b0;
			wait_reg <= 1'b0;
			o_adc_start <= 1'b0;
			o_adc_sel <= SEL_CELL;
			o_ref_sel_thermistor <= 1'b0;
			result_reg <= `SDM_RESULT_RST;
		end else begin
			o_adc_start <= 1'b0;

			// Start pulses last one cycle; default low
			case (state_reg)
			ST_IDLE: begin
				if (scan_go) begin
					busy_reg <= 1'b1;
					cnt_reg <= 16'h0000;
					state_reg <= ST_PWRUP;
				end
			end

			ST_PWRUP: begin
				// Converter settles before the first cell
				cnt_reg <= cnt_reg + 16'h0001;
				if (cnt_reg >= PWRUP_CYC[15:0] - 16'h0001) begin
					cell_reg <= first_cell;
					state_reg <= ST_CELL;
				end
			end

			ST_CELL: begin
				if (cell_reg >= CELLS[3:0]) begin
					if (selftest_enable_bit) begin
						state_reg <= ST_SELF;
						o_adc_start <= 1'b1;
						o_adc_sel <= SEL_SELF;
						o_ref_sel_thermistor <= 1'b1;
						wait_reg <= 1'b1;
					end else begin
						state_reg <= ST_AUX1;
					end
				end else if (!wait_reg) begin
					o_adc_start <= 1'b1;
					o_adc_sel <= SEL_CELL;
					wait_reg <= 1'b1;
				end else if (i_adc_done) begin
					wait_reg <= 1'b0;
					cell_reg <= after_cell;
					// start self-test on last cell done
					if (after_cell >= CELLS[3:0] && selftest_enable_bit) begin
						state_reg <= ST_SELF;
						o_adc_start <= 1'b1;
						o_adc_sel <= SEL_SELF;
						o_ref_sel_thermistor <= 1'b1;
						wait_reg <= 1'b1;
					end
				end
			end

			ST_SELF: begin
				if (conv_fin) begin
					wait_reg <= 1'b0;
					o_ref_sel_thermistor <= 1'b0;
					// every self-test code passes through for the host, healthy or not
					result_reg <= {i_adc_code, 4'h0};
					state_reg <= ST_AUX1;
				end
			end

			ST_AUX1: begin
				if (!aux1_en) begin
					state_reg <= ST_AUX2;
				end else if (!wait_reg) begin
					o_adc_start <= 1'b1;
					o_adc_sel <= SEL_AUX1;
					wait_reg <= 1'b1;
				end else if (i_adc_done) begin
					wait_reg <= 1'b0;
					state_reg <= ST_AUX2;
				end
			end

			ST_AUX2: begin
				if (aux2_en && !wait_reg) begin
					o_adc_start <= 1'b1;
					o_adc_sel <= SEL_AUX2;
					wait_reg <= 1'b1;
				end else if (!aux2_en || i_adc_done) begin
					wait_reg <= 1'b0;
					busy_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
			end

			default: begin
				state_reg <= ST_IDLE;
				busy_reg <= 1'b0;
				wait_reg <= 1'b0;
			end
			endcase
		end
	end

	// Event flags: a new event wins over the read that clears
	wire ev_set_done_w = state_reg == ST_SELF && conv_fin;
	wire ev_set_scan = state_reg == ST_AUX2 && (!aux2_en || (wait_reg && i_adc_done));
	// Event bits in status layout: scan, reference, self-test
	wire [2:0] ev_vec = {ev_set_scan, ref_osc, ev_set_done_w};
	wire [2:0] stat_next = rd_stat ? ev_vec : (stat_reg | ev_vec);

	// Register writes and read data; zero wait states, always OKAY
	always @(posedge i_clk) begin
		if (i_rst) begin
			cfg_reg <= 16'h0000;
			cell_en_reg <= 16'h0FFF;
			mask_reg <= 3'b000;
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;

			if (wr_cfg) begin
				cfg_reg <= i_hwdata[15:0];
			end
			if (wr_cells) begin
				cell_en_reg <= i_hwdata[15:0];
			end
			if (wr_mask) begin
				mask_reg <= i_hwdata[2:0];
			end

			if (rd_ap) begin
				o_hrdata <= read_word(i_haddr[7:0]);
			end else begin
				o_hrdata <= 32'h00000000;
			end
		end
	end

	// oscillation sets open alert; set wins over a clear
	always @(posedge i_clk) begin
		if (i_rst) begin
			fault_reg <= 1'b0;
		end else if (ref_osc) begin
			fault_reg <= 1'b1;
		end else if (wr_fault && !i_hwdata[`SDM_FAULT_REFOPEN_BIT]) begin
			fault_reg <= 1'b0;
		end
	end

	// Sticky events; a read clears, but an event in that cycle stays
	always @(posedge i_clk) begin
		if (i_rst) begin
			stat_reg <= 3'b000;
		end else begin
			stat_reg <= stat_next;
		end
	end

	// Interrupt follows the status as it will stand, so it drops with the read
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(stat_next & mask_reg);
		end
	end
endmodule
`default_nettype wire

// ==== sdm_defs.vh ====
// Register offsets, field positions, reset values and timing counts for the self-test block
`ifndef SDM_DEFS_VH
`define SDM_DEFS_VH
`define SDM_OFF_CFG 8'h08
`define SDM_OFF_CTRL 8'h0D
`define SDM_OFF_FAULT 8'h0E
`define SDM_OFF_RESULT 8'h20
`define SDM_OFF_STAT 8'h24
`define SDM_OFF_IRQ 8'h28
`define SDM_OFF_MASK 8'h2C
`define SDM_OFF_STATE 8'h30
`define SDM_CFG_SELFTEST_BIT 0
`define SDM_CFG_AUX1_BIT 1
`define SDM_CFG_AUX2_BIT 2
`define SDM_CTRL_SCAN_BIT 0
`define SDM_FAULT_REFOPEN_BIT 0
`define SDM_IRQ_DONE_BIT 0
`define SDM_IRQ_REFOPEN_BIT 1
`define SDM_IRQ_SCAN_BIT 2
`define SDM_RESULT_RST 16'h0000
`define SDM_NOMINAL_CODE 12'h5E1
`define SDM_OK_LO 12'h54B
`define SDM_OK_HI 12'h677
`define SDM_C0OPEN_LO 12'h1DA
`define SDM_C0OPEN_HI 12'h1DC
`define SDM_REFGND_LO 12'h292
`define SDM_REFGND_HI 12'h293
`define SDM_FULL_SCALE_MV 3400
`define SDM_PWRUP_NS 2000
`define SDM_CLK_NS 50
`define SDM_PWRUP_CYC ((`SDM_PWRUP_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_OSC_EDGES 4
`endif

// ==== sdm_osc_det.v ====
// Oscillation detector for the reference pin comparator
`default_nettype none
module sdm_osc_det #(
	parameter EDGES = 4,
	parameter WIN = 64
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_level,
	output reg o_detect
);
	reg prev_reg;
	reg [7:0] edge_reg;
	reg [7:0] win_reg;
	wire toggled = i_level ^ prev_reg;
	// Count transitions per window; a stable level never trips it
	always @(posedge i_clk) begin
		if (i_rst) begin
			prev_reg <= 1'b0;
			edge_reg <= 8'h00;
			win_reg <= 8'h00;
			o_detect <= 1'b0;
		end else begin
			prev_reg <= i_level;
			o_detect <= 1'b0;
			if (win_reg == WIN[7:0] - 8'h01) begin
				win_reg <= 8'h00;
				edge_reg <= 8'h00;
			end else begin
				win_reg <= win_reg + 8'h01;
				if (toggled) begin
					edge_reg <= edge_reg + 8'h01;
					if (edge_reg + 8'h01 >= EDGES[7:0])
						o_detect <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== sdm_chk_asserts.sv ====
// Port assertions for the self-test sequencer
`default_nettype none
module sdm_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic i_hready,
	input wire logic i_adc_done,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_adc_start,
	input wire logic [1:0] o_adc_sel,
	input wire logic o_ref_sel_thermistor
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rd_res_reg;
	logic pend_reg;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Track result reads and open self-test conversions
	always @(posedge i_clk) begin
		rd_res_reg <= !i_rst && i_hsel && i_hready && i_htrans[1] && !i_hwrite
			&& i_haddr == 32'h20;
		if (i_rst || i_adc_done)
			pend_reg <= 1'b0;
		else if (o_adc_start && o_adc_sel == 2'h1)
			pend_reg <= 1'b1;
	end
	AST_BUS: assert property (o_hreadyout && !o_hresp) else $error("bus answer not OKAY");
	AST_PULSE: assert property (o_adc_start |=> !o_adc_start) else $error("start too long");
	AST_SEL: assert property (o_adc_start |=> $stable(o_adc_sel)) else $error("sel moved");
	AST_REF: assert property (o_adc_start && o_adc_sel == 2'h1 |-> o_ref_sel_thermistor)
		else $error("self-test without thermistor reference");
	AST_REF_ONLY: assert property (o_ref_sel_thermistor |-> o_adc_sel == 2'h1)
		else $error("thermistor reference outside self-test");
	AST_NOGAP: assert property (o_adc_start && o_adc_sel == 2'h1 |->
		$past(i_adc_done) && $past(o_adc_sel) == 2'h0) else $error("self-test not after cell");
	AST_AUX: assert property (o_adc_start && o_adc_sel[1] |-> !pend_reg)
		else $error("aux before self-test done");
	AST_NIB: assert property (rd_res_reg |-> o_hrdata[3:0] == 4'h0
		&& o_hrdata[31:16] == 16'h0) else $error("result bits misplaced");
	cover property (o_adc_start && o_adc_sel == 2'h1);
	cover property (o_adc_start && o_adc_sel == 2'h3);
	cover property (rd_res_reg);
endmodule
bind sdm_top sdm_chk u_sdm_chk (.*);
`default_nettype wire

// ==== tb_self_diagnostic_measurement.sv ====
// Self-checking bench for the self-test sequencer
`default_nettype none
module tb_self_diagnostic_measurement;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0, i_adc_done = 0, i_ref_level = 0;
	logic o_hreadyout, o_hresp, o_adc_start, o_ref_sel_thermistor, o_irq;
	logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, r, seq_reg = 0;
	logic [1:0] i_htrans = 0, o_adc_sel, sel_reg = 0;
	logic [11:0] i_adc_code = 0;
	logic [2:0] dly_reg = 0;
	int err_total = 0, cmp_count = 0, exp_code = 0, e, base = 0;
	sdm_top #(.PWRUP_CYC(2)) u_sdm_top (.i_hready(o_hreadyout), .i_hsize(3'h2), .*);
	initial forever #25 i_clk = ~i_clk;
	// Converter stand-in answers three cycles after each start
	always @(posedge i_clk) begin
		dly_reg <= {dly_reg[1:0], o_adc_start};
		i_adc_done <= dly_reg[1];
		if (o_adc_start) begin
			sel_reg <= o_adc_sel;
			seq_reg <= (o_adc_sel == 2'h0) ? 32'h0 : {seq_reg[29:0], o_adc_sel};
			i_adc_code <= 12'h5DD + 12'($urandom_range(8));
		end
		if (dly_reg[1] && sel_reg == 2'h1)
			exp_code <= i_adc_code;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1;
		i_haddr <= a;
		i_htrans <= 2'h2;
		i_hwrite <= w;
		do @(posedge i_clk); while (!o_hreadyout);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(posedge i_clk); while (!o_hreadyout);
		r = o_hrdata;
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			$display("[FAIL] %s exp %h got %h", n, x, g);
			err_total++;
		end
	endtask
	task rc(input string n, input logic [7:0] a, input logic [31:0] x);
		xfer(0, a, 0);
		chk(n, x, r);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		err_total++;
		print_verdict;
	end
	initial begin
		void'($urandom(32'hB61B5548));
		repeat (5) @(posedge i_clk);
		i_rst <= 0;
		rc("cfg", 8'h08, 0);
		rc("result", 8'h20, 0);
		rc("cells", 8'h30, 32'hFFF);
		rc("unmapped", 8'h40, 0);
		xfer(1, 8'h2C, 32'h4);
		// Every enable combination, scan-done interrupt only
		for (int t = 0; t < 8; t++) begin
			xfer(1, 8'h08, t);
			xfer(1, 8'h0D, 1);
			for (int k = 0; k < 400 && o_irq !== 1'b1; k++) @(posedge i_clk);
			e = 0;
			if (t[0]) e = 1;
			if (t[1]) e = e * 4 + 2;
			if (t[2]) e = e * 4 + 3;
			chk("order", e, seq_reg);
			rc("status", 8'h28, 32'h4 | t[0]);
			repeat (2) @(posedge i_clk);
			chk("irq", 0, o_irq);
			rc("result", 8'h20, {exp_code[11:0], 4'h0});
			if (t[0]) begin
				if (t == 1)
					base = r[15:4];
				chk("range", 1, r[15:4] >= 12'h54B && r[15:4] <= 12'h677);
				chk("drift", 1, r[15:4] + 4 >= base && r[15:4] <= base + 4);
			end
			$display("test scan %0d done", t);
		end
		// Oscillating reference pin, its event masked
		repeat (8) @(posedge i_clk) i_ref_level <= ~i_ref_level;
		repeat (2) @(posedge i_clk);
		chk("irq masked", 0, o_irq);
		rc("alert", 8'h0E, 1);
		chk("alert bit", 1, r[0]);
		rc("status", 8'h28, 2);
		repeat (70) @(posedge i_clk);
		xfer(1, 8'h0E, 0);
		rc("alert clear", 8'h0E, 0);
		$display("test reference done");
		print_verdict;
	end
endmodule
`default_nettype wire
